/* shared/ids_pkg.sv */
package ids_pkg;
    // address space layout
    localparam int          IDS_RAM_DEPTH   = 256;
    localparam int          IDS_AW          = 8;
    localparam int          IDS_DW          = 8;
    localparam logic [7:0]  IDS_UPPER_BASE  = 8'h80;
    localparam logic [7:0]  IDS_BIT_BASE    = 8'h20;
    localparam logic [7:0]  IDS_BIT_END     = 8'h2F;
    localparam logic [7:0]  IDS_BANK_END    = 8'h1F;
    localparam int          IDS_BANK_SEL_W  = 2;
    localparam int          IDS_REG_SEL_W   = 3;
    localparam logic [7:0]  IDS_RESET_DATA  = 8'h00;
    localparam logic [1:0]  IDS_RESET_BANK  = 2'h0;
    localparam logic [6:0]  IDS_SFR_OFFSET_MASK = 7'h7F;

    // access modes issued by the core
    typedef enum logic [3:0] {
        IDS_MODE_DIRECT   = 4'h1,
        IDS_MODE_INDIRECT = 4'h2,
        IDS_MODE_BIT      = 4'h4,
        IDS_MODE_REG      = 4'h8
    } ids_mode_t;

    // routing target, one-hot
    typedef enum logic [2:0] {
        IDS_TGT_NONE = 3'h1,
        IDS_TGT_RAM  = 3'h2,
        IDS_TGT_SFR  = 3'h4
    } ids_tgt_t;
endpackage

/* core/ids_bank_map.sv */
`timescale 1ns/1ps
`default_nettype none
module ids_bank_map
    import ids_pkg::*;
(
    // bank select and register operand
    input  wire logic [ids_pkg::IDS_BANK_SEL_W-1:0] bank_sel,
    input  wire logic [ids_pkg::IDS_REG_SEL_W-1:0]  reg_sel,
    // ram byte address of the working register
    output logic [ids_pkg::IDS_AW-1:0]              reg_addr
);
    import ids_pkg::*;

    // bank occupies eight bytes: bank*8 + reg, zero above
    assign reg_addr = {3'h0, bank_sel, reg_sel}; // RULE_05 RULE_07
endmodule
`default_nettype wire

/* core/ids_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// (RULE_01) Holds 256 data bytes where the top half is shared by RAM and SFR space by mode.
// (RULE_02) Indirect accesses at 0x80 and above read or write upper RAM.
// (RULE_03) Direct accesses at 0x80 and above go to the 128-location SFR port, not RAM.
// (RULE_04) Below 0x80 direct and indirect accesses hit the same RAM byte.
// (RULE_05) Bytes 0x00 to 0x1F form four banks of eight working registers.
// (RULE_06) Bytes 0x20 to 0x2F are reachable as bytes or single bits.
// (RULE_07) A two-bit bank select from the status word picks the bank for register operands.
module ids_decoder
    import ids_pkg::*;
(
    // clock and control
    input  wire logic                             mclk,
    input  wire logic                             sys_rst,
    input  wire logic                             clk_en,
    // core access request
    input  wire logic                             acc_req,
    input  wire logic                             acc_we,
    input  wire ids_pkg::ids_mode_t               acc_mode,
    input  wire logic [ids_pkg::IDS_AW-1:0]       acc_addr,
    input  wire logic [ids_pkg::IDS_DW-1:0]       acc_wdata,
    input  wire logic [ids_pkg::IDS_BANK_SEL_W-1:0] psw_bank,
    // core answer
    output logic                                  rd_valid_ff,
    output logic [ids_pkg::IDS_DW-1:0]            rd_data_ff,
    output logic                                  acc_err_ff,
    // sfr space port
    output logic                                  sfr_req_ff,
    output logic                                  sfr_we_ff,
    output logic [6:0]                            sfr_addr_ff,
    output logic [ids_pkg::IDS_DW-1:0]            sfr_wdata_ff,
    input  wire logic [ids_pkg::IDS_DW-1:0]       sfr_rdata
);
    import ids_pkg::*;

    logic [IDS_DW-1:0] mem_ff [IDS_RAM_DEPTH];
    logic [IDS_AW-1:0] reg_addr;
    logic [IDS_AW-1:0] ram_addr;
    logic [IDS_AW-1:0] bit_byte;
    logic [2:0]        bit_pos;
    logic              bit_ok;
    ids_tgt_t          tgt;
    logic              sfr_pend_ff;
    logic              nxt_bit;

    // bit number 0..127 maps to byte 0x20 + n/8
    function automatic logic [IDS_AW-1:0] bit_to_byte(input logic [IDS_AW-1:0] bn);
        bit_to_byte = IDS_BIT_BASE + {3'h0, bn[6:2] >> 1'b1 & 5'h0F} ;
    endfunction

    function automatic logic is_upper(input logic [IDS_AW-1:0] a);
        is_upper = (a >= IDS_UPPER_BASE);
    endfunction

    ids_bank_map u_bank (
        .bank_sel (psw_bank),
        .reg_sel  (acc_addr[IDS_REG_SEL_W-1:0]),
        .reg_addr (reg_addr)
    );

    assign bit_byte = bit_to_byte(acc_addr); // RULE_06
    assign bit_pos  = acc_addr[2:0];
    assign bit_ok   = (acc_addr < IDS_UPPER_BASE); // upper bit space belongs to sfrs

    // route by mode; top half is split by mode, bottom half shared
    always_comb begin
        tgt      = IDS_TGT_NONE;
        ram_addr = acc_addr;
        case (acc_mode)
            IDS_MODE_DIRECT: begin
                tgt = is_upper(acc_addr) ? IDS_TGT_SFR : IDS_TGT_RAM; // RULE_01 RULE_03 RULE_04
            end
            IDS_MODE_INDIRECT: begin
                tgt = IDS_TGT_RAM; // RULE_02 RULE_04
            end
            IDS_MODE_BIT: begin
                tgt      = bit_ok ? IDS_TGT_RAM : IDS_TGT_NONE; // RULE_06
                ram_addr = bit_byte;
            end
            IDS_MODE_REG: begin
                tgt      = IDS_TGT_RAM;
                ram_addr = reg_addr; // RULE_07
            end
            default: begin
                tgt = IDS_TGT_NONE;
            end
        endcase
    end

    // ram write; bit writes modify one bit, lsb of wdata carries it
    // contents survive reset, but no write may land while reset is held
    always_ff @(posedge mclk) begin
        if (!sys_rst && clk_en && acc_req && acc_we && tgt == IDS_TGT_RAM) begin
            if (acc_mode == IDS_MODE_BIT) begin
                mem_ff[ram_addr][bit_pos] <= acc_wdata[0]; // RULE_06
            end else begin
                mem_ff[ram_addr] <= acc_wdata; // RULE_02 RULE_04
            end
        end
    end

    assign nxt_bit = mem_ff[ram_addr][bit_pos];

    // read answer one cycle after request; sfr reads wait one more for the peripheral
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rd_valid_ff <= 1'b0;
            rd_data_ff  <= IDS_RESET_DATA;
            acc_err_ff  <= 1'b0;
            sfr_pend_ff <= 1'b0;
        end else if (clk_en) begin
            rd_valid_ff <= 1'b0;
            acc_err_ff  <= 1'b0;
            sfr_pend_ff <= 1'b0;
            if (sfr_pend_ff) begin
                rd_valid_ff <= 1'b1;
                rd_data_ff  <= sfr_rdata; // RULE_03
            end
            if (acc_req) begin
                case (tgt)
                    IDS_TGT_RAM: begin
                        // a ram write must not cancel an sfr answer due in this cycle
                        // limitation: a ram read right behind an sfr read takes the slot
                        if (!acc_we) begin
                            rd_valid_ff <= 1'b1;
                            rd_data_ff <= (acc_mode == IDS_MODE_BIT) ?
                                          {7'h00, nxt_bit} : mem_ff[ram_addr];
                        end
                    end
                    IDS_TGT_SFR: begin
                        sfr_pend_ff <= !acc_we;
                    end
                    default: begin
                        acc_err_ff <= 1'b1; // bad mode or sfr bit: flagged, ignored
                    end
                endcase
            end
        end
    end

    // sfr port strobe, one cycle, registered
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sfr_req_ff   <= 1'b0;
            sfr_we_ff    <= 1'b0;
            sfr_addr_ff  <= 7'h00;
            sfr_wdata_ff <= IDS_RESET_DATA;
        end else if (clk_en) begin
            sfr_req_ff <= acc_req && tgt == IDS_TGT_SFR; // RULE_03
            if (acc_req && tgt == IDS_TGT_SFR) begin
                sfr_we_ff    <= acc_we;
                sfr_addr_ff  <= acc_addr[6:0] & IDS_SFR_OFFSET_MASK;
                sfr_wdata_ff <= acc_wdata;
            end
        end
    end

    // upper direct access never reaches ram
    sfr_route_a: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && acc_req && acc_mode == IDS_MODE_DIRECT && acc_addr[7]
        |=> sfr_req_ff && sfr_addr_ff == $past(acc_addr[6:0]))
        else $error("direct upper access not sent to sfr port"); // RULE_03
    indirect_ram_a: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && acc_req && acc_mode == IDS_MODE_INDIRECT
        |=> !sfr_req_ff)
        else $error("indirect access reached sfr port"); // RULE_02
    ram_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && acc_req && !acc_we && acc_mode == IDS_MODE_INDIRECT
        |=> rd_valid_ff && !acc_err_ff)
        else $error("indirect read not answered next cycle"); // RULE_01
    lower_direct_a: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && acc_req && acc_mode == IDS_MODE_DIRECT && !acc_addr[7]
        |=> !sfr_req_ff)
        else $error("lower direct access went to sfr"); // RULE_04
    bank_addr_a: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_mode == IDS_MODE_REG |-> reg_addr <= IDS_BANK_END &&
        reg_addr[4:3] == psw_bank)
        else $error("register operand outside selected bank"); // RULE_05
    bank_sel_a: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_mode == IDS_MODE_REG |-> ram_addr == {3'h0, psw_bank, acc_addr[2:0]})
        else $error("bank select not applied"); // RULE_07
    bit_byte_a: assert property (@(posedge mclk) disable iff (sys_rst)
        acc_mode == IDS_MODE_BIT && bit_ok |-> ram_addr >= IDS_BIT_BASE &&
        ram_addr <= IDS_BIT_END)
        else $error("bit access outside bit region"); // RULE_06
    sfr_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && acc_req && !acc_we && acc_mode == IDS_MODE_DIRECT && acc_addr[7]
        ##1 clk_en |=> rd_valid_ff)
        else $error("sfr read not answered in two cycles"); // RULE_03
endmodule
`default_nettype wire

/* testbench/ids_sfr_model.sv */
`timescale 1ns/1ps
`default_nettype none
// stand-in for the special function register space behind the decoder
module ids_sfr_model (
    // clock and sfr request
    input  wire logic       mclk,
    input  wire logic       sfr_req_ff,
    input  wire logic       sfr_we_ff,
    input  wire logic [6:0] sfr_addr_ff,
    input  wire logic [7:0] sfr_wdata_ff,
    // read answer
    output logic [7:0]      sfr_rdata
);
    logic [7:0] mem [128];
    logic       hold_ff;
    logic [7:0] last_ff;
    // known start pattern, mirrored by the bench
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = i[7:0] ^ 8'h5A;
    end
    // writes land in the 128-location space; reads held two cycles
    always @(posedge mclk) begin
        hold_ff <= sfr_req_ff & ~sfr_we_ff;
        last_ff <= sfr_rdata;
        if (sfr_req_ff && sfr_we_ff) mem[sfr_addr_ff] <= sfr_wdata_ff;
    end
    // outside a read the bus shows its previous value inverted, so it toggles and every other cycle shows the last value
    assign sfr_rdata = ((sfr_req_ff & ~sfr_we_ff) | hold_ff) ? mem[sfr_addr_ff] : ~last_ff;
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ids_pkg::*;
    logic       mclk = 0, sys_rst = 1, clk_en = 1, acc_req = 0, acc_we = 0;
    ids_mode_t  acc_mode = IDS_MODE_DIRECT;
    logic [7:0] acc_addr = 0, acc_wdata = 0, rd_data_ff, sfr_wdata_ff, sfr_rdata, got;
    logic [7:0] ram_e [256], sfr_e [128];
    logic [1:0] psw_bank = 0;
    logic       rd_valid_ff, acc_err_ff, sfr_req_ff, sfr_we_ff;
    logic [6:0] sfr_addr_ff;
    int         bad_count = 0, n_checks = 0, cyc = 0, i, a, b;

    always #20 mclk = ~mclk;

    ids_decoder ids_decoder_inst (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
        .acc_req(acc_req), .acc_we(acc_we), .acc_mode(acc_mode), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .psw_bank(psw_bank), .rd_valid_ff(rd_valid_ff),
        .rd_data_ff(rd_data_ff), .acc_err_ff(acc_err_ff), .sfr_req_ff(sfr_req_ff),
        .sfr_we_ff(sfr_we_ff), .sfr_addr_ff(sfr_addr_ff), .sfr_wdata_ff(sfr_wdata_ff),
        .sfr_rdata(sfr_rdata));
    ids_sfr_model ids_sfr_model_inst (.mclk(mclk), .sfr_req_ff(sfr_req_ff),
        .sfr_we_ff(sfr_we_ff), .sfr_addr_ff(sfr_addr_ff), .sfr_wdata_ff(sfr_wdata_ff),
        .sfr_rdata(sfr_rdata));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard, run needs about 750 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // one request cycle; outputs of the answer cycle are settled on return
    task automatic acc(logic we, ids_mode_t m, logic [7:0] ad, logic [7:0] wd);
        @(negedge mclk);
        acc_req = 1; acc_we = we; acc_mode = m; acc_addr = ad; acc_wdata = wd;
        @(negedge mclk);
        acc_req = 0;
    endtask
    task automatic wait_rd();
        for (int k = 0; k < 3 && rd_valid_ff !== 1'b1; k++) @(negedge mclk);
        got = (rd_valid_ff === 1'b1) ? rd_data_ff : 8'hXX;
    endtask
    task automatic rd(ids_mode_t m, logic [7:0] ad);
        acc(0, m, ad, 8'h00);
        wait_rd();
    endtask

    initial begin
        void'($urandom(32'h59FE));
        for (i = 0; i < 128; i++) sfr_e[i] = i[7:0] ^ 8'h5A;
        repeat (3) @(negedge mclk);
        sys_rst = 0;
        for (i = 0; i < 20; i++) begin
            a = (i == 0) ? 127 : $urandom % 128;
            b = $urandom % 256;
            acc(1, IDS_MODE_DIRECT, a, b);
            ram_e[a] = b;
            rd(IDS_MODE_INDIRECT, a);
            chk("low_ram", ram_e[a], got);
        end
        $display("test low_half done");
        for (i = 0; i < 20; i++) begin
            a = (i == 0) ? 128 : 128 + $urandom % 128;
            b = $urandom % 256;
            acc(1, IDS_MODE_INDIRECT, a, b);
            ram_e[a] = b;
            chk("ind_no_sfr", 8'h00, sfr_req_ff);
            acc(1, IDS_MODE_DIRECT, a, ~b);
            sfr_e[a - 128] = ~b;
            chk("sfr_wr", {1'b1, a[6:0]}, {sfr_we_ff & sfr_req_ff, sfr_addr_ff});
            chk("sfr_wd", sfr_e[a - 128], sfr_wdata_ff);
            acc(0, IDS_MODE_DIRECT, a, 8'h00);
            chk("sfr_rq", {1'b1, a[6:0]}, {sfr_req_ff & ~sfr_we_ff, sfr_addr_ff});
            wait_rd();
            chk("sfr_rd", sfr_e[a - 128], got);
            rd(IDS_MODE_INDIRECT, a);
            chk("up_ram", ram_e[a], got);
        end
        $display("test upper_half done");
        for (i = 0; i < 32; i++) begin
            psw_bank = i / 8;
            b = $urandom % 256;
            acc(1, IDS_MODE_REG, i % 8, b);
            ram_e[i] = b;
            rd(IDS_MODE_DIRECT, i);
            chk("bank_byte", ram_e[i], got);
            rd(IDS_MODE_REG, i % 8);
            chk("bank_reg", ram_e[i], got);
        end
        $display("test banks done");
        for (i = 0; i < 16; i++) acc(1, IDS_MODE_DIRECT, 32 + i, 8'h00);
        for (i = 0; i < 16; i++) ram_e[32 + i] = 8'h00;
        for (i = 0; i < 40; i++) begin
            a = (i == 0) ? 0 : (i == 1) ? 127 : $urandom % 128;
            b = $urandom % 2;
            acc(1, IDS_MODE_BIT, a, b);
            ram_e[32 + a / 8][a % 8] = b[0];
            rd(IDS_MODE_DIRECT, 32 + a / 8);
            chk("bit_byte", ram_e[32 + a / 8], got);
            rd(IDS_MODE_BIT, a);
            chk("bit_rd", b, got);
        end
        $display("test bits done");
        acc(1, IDS_MODE_BIT, 200, 8'h01);
        chk("bit_err", 8'h01, acc_err_ff);
        acc(0, ids_mode_t'(4'h3), 8'h00, 8'h00);
        chk("mode_err", 8'h01, acc_err_ff);
        clk_en = 0;
        acc(0, IDS_MODE_DIRECT, 5, 8'h00);
        chk("frozen", 8'h00, rd_valid_ff);
        clk_en = 1;
        // sfr read answer must survive a ram write issued right behind it
        @(negedge mclk);
        acc_req = 1;
        acc_we = 0;
        acc_mode = IDS_MODE_DIRECT;
        acc_addr = 8'h85;
        @(negedge mclk);
        acc_we = 1;
        acc_mode = IDS_MODE_INDIRECT;
        acc_addr = 8'h40;
        acc_wdata = 8'h3C;
        @(negedge mclk);
        acc_req = 0;
        ram_e[8'h40] = 8'h3C;
        chk("sfr_b2b", sfr_e[5], (rd_valid_ff === 1'b1) ? rd_data_ff : 8'hXX);
        rd(IDS_MODE_INDIRECT, 8'h40);
        chk("b2b_ram", ram_e[8'h40], got);
        // mid-run reset drops a pending sfr answer and clears the outputs
        acc(0, IDS_MODE_DIRECT, 8'h85, 8'h00);
        sys_rst = 1;
        @(negedge mclk);
        sys_rst = 0;
        chk("rst_valid", 8'h00, rd_valid_ff);
        chk("rst_sfr", 8'h00, sfr_req_ff);
        chk("rst_data", IDS_RESET_DATA, rd_data_ff);
        $display("test refusals done");
        report_and_stop();
    end
endmodule
`default_nettype wire
